// [rtl/plg_pkg.sv]
/*
  Package for the programmable boolean logic engine: sizes, type codes, gate
  costs, capacities, reset values and the timebase count.
  Assumes a single 25 MHz relay clock shared by every user of the package.
*/
// Behaviour
// R1 - Evaluate user network of boolean logic functions.
// R2 - Gate cost: one, two or four by type.
// R3 - Up to 32 input gates, any inputs each.
// R4 - At most 20 distinct logic outputs.
// R5 - Report input, gate and output usage percentages.
// R6 - Loader keeps every usage at or below 100%; the code only flags excess on over_o and does not block the load.
// R7 - New function starts as AND type.
// R8 - Type selectable: AND, OR, counter, latch variants.
// R9 - Counter type uses its own count setting.
// R10 - Separate activation and deactivation delays per function.
// R11 - Optional output inversion per function.
// R12 - Function outputs can feed other functions.
// R13 - New configuration acts only after restart.
// R14 - After restart, outputs appear in output matrix.
// R15 - Counter counts rising edges, reset clears it.
// R16 - Latch reset beats set; load captures data.
package plg_pkg;
  localparam int NUM_FUNC   = 32;  // Function slots, one per possible gate resource.
  localparam int FIDX_W     = 5;   // Width of a function slot index.
  localparam int NUM_SIG    = 32;  // External boolean status signals.
  localparam int SRC_W      = 64;  // Source vector: signals then function outputs.
  localparam int NUM_OUT    = 20;  // Logic output signals towards the matrix.
  localparam int OSEL_W     = 5;   // Width of a logic output number.
  localparam int CNT_W      = 16;  // Width of count and delay settings.
  localparam int PCT_W      = 9;   // Width of a usage percentage (up to 400).
  localparam int GATE_CAP   = 32;  // Gate resources available.
  localparam int INGATE_CAP = 32;  // Input gates available.
  localparam int OUT_CAP    = 20;  // Logic outputs available.
  localparam int PCT_FULL   = 100; // Percentage scale.
  localparam int CLK_MHZ    = 25;  // Clock rate in MHz.
  localparam int TICK_US    = 1000; // Delay timebase in microseconds.
  localparam int TICK_CYC   = TICK_US * CLK_MHZ; // Cycles per delay tick.
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000; // Reset value of counts.

  // Function type codes.
  typedef enum logic [3:0] {
    PLG_AND     = 4'h0,
    PLG_OR      = 4'h1,
    PLG_XOR     = 4'h2,
    PLG_AND_OR  = 4'h3,
    PLG_OR_AND  = 4'h4,
    PLG_INV_AND = 4'h5,
    PLG_INV_OR  = 4'h6,
    PLG_CNT     = 4'h7,
    PLG_SRL     = 4'h8,
    PLG_SDL     = 4'h9
  } plg_func_e;

  // Gate resources taken by each type.
  localparam logic [2:0] COST_ONE  = 3'h1;
  localparam logic [2:0] COST_TWO  = 3'h2;
  localparam logic [2:0] COST_FOUR = 3'h4;
endpackage

// [rtl/plg_engine.sv]
/*
  Programmable boolean logic engine. Holds a pending (written) configuration
  and an active one; the active copy is refreshed only on restart. Each of the
  32 function slots evaluates its type over selected sources, applies on and
  off delays and optional inversion, and may drive one of 20 logic outputs.
  Assumes sig_i comes from pins outside the clock domain, and every cfg_ and
  restart_i input comes from logic on clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module plg_engine
  import plg_pkg::*;
#(
  parameter int TICK_CYCLES = plg_pkg::TICK_CYC
) (
  // Clock and reset.
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // Boolean status signals from digital and virtual inputs.
  input  wire logic [plg_pkg::NUM_SIG-1:0]  sig_i,
  // Configuration loading from the setting tool side.
  input  wire logic                         cfg_new_i,
  input  wire logic                         cfg_del_i,
  input  wire logic                         cfg_wr_i,
  input  wire logic [plg_pkg::FIDX_W-1:0]   cfg_idx_i,
  input  wire logic [3:0]                   cfg_type_i,
  input  wire logic [plg_pkg::SRC_W-1:0]    cfg_mask_a_i,
  input  wire logic [plg_pkg::SRC_W-1:0]    cfg_mask_b_i,
  input  wire logic [plg_pkg::SRC_W-1:0]    cfg_mask_c_i,
  input  wire logic [plg_pkg::SRC_W-1:0]    cfg_mask_d_i,
  input  wire logic [plg_pkg::CNT_W-1:0]    cfg_count_i,
  input  wire logic [plg_pkg::CNT_W-1:0]    cfg_on_dly_i,
  input  wire logic [plg_pkg::CNT_W-1:0]    cfg_off_dly_i,
  input  wire logic                         cfg_inv_i,
  input  wire logic                         cfg_out_en_i,
  input  wire logic [plg_pkg::OSEL_W-1:0]   cfg_out_sel_i,
  input  wire logic                         restart_i,
  // Results towards the output matrix.
  output logic      [plg_pkg::NUM_OUT-1:0]  logic_out_o,
  output logic      [plg_pkg::NUM_OUT-1:0]  out_avail_o,
  output logic      [plg_pkg::NUM_FUNC-1:0] func_out_o,
  // Usage report of the pending configuration.
  output logic      [plg_pkg::PCT_W-1:0]    pct_in_o,
  output logic      [plg_pkg::PCT_W-1:0]    pct_gate_o,
  output logic      [plg_pkg::PCT_W-1:0]    pct_out_o,
  output logic                              over_o
);
  import plg_pkg::*;
  // Pending configuration, written by the tool side.
  logic                  p_used_r  [NUM_FUNC];
  logic [3:0]            p_type_r  [NUM_FUNC];
  logic [SRC_W-1:0]      p_ma_r    [NUM_FUNC];
  logic [SRC_W-1:0]      p_mb_r    [NUM_FUNC];
  logic [SRC_W-1:0]      p_mc_r    [NUM_FUNC];
  logic [SRC_W-1:0]      p_md_r    [NUM_FUNC];
  logic [CNT_W-1:0]      p_cnt_r   [NUM_FUNC];
  logic [CNT_W-1:0]      p_on_r    [NUM_FUNC];
  logic [CNT_W-1:0]      p_off_r   [NUM_FUNC];
  logic                  p_inv_r   [NUM_FUNC];
  logic                  p_oen_r   [NUM_FUNC];
  logic [OSEL_W-1:0]     p_osel_r  [NUM_FUNC];
  // Active configuration, the one the network runs on.
  logic                  a_used_r  [NUM_FUNC];
  logic [3:0]            a_type_r  [NUM_FUNC];
  logic [SRC_W-1:0]      a_ma_r    [NUM_FUNC];
  logic [SRC_W-1:0]      a_mb_r    [NUM_FUNC];
  logic [SRC_W-1:0]      a_mc_r    [NUM_FUNC];
  logic [SRC_W-1:0]      a_md_r    [NUM_FUNC];
  logic [CNT_W-1:0]      a_cnt_r   [NUM_FUNC];
  logic [CNT_W-1:0]      a_on_r    [NUM_FUNC];
  logic [CNT_W-1:0]      a_off_r   [NUM_FUNC];
  logic                  a_inv_r   [NUM_FUNC];
  logic                  a_oen_r   [NUM_FUNC];
  logic [OSEL_W-1:0]     a_osel_r  [NUM_FUNC];

  logic [NUM_SIG-1:0]    sig_m_r;   // First synchroniser stage.
  logic [NUM_SIG-1:0]    sig_s_r;   // Second synchroniser stage.
  logic [15:0]           tick_cnt_r; // Delay timebase divider.
  logic                  tick_r;    // One-cycle pulse per delay tick.
  logic [NUM_FUNC-1:0]   fq_r;      // Function outputs after delay and inversion.
  wire  [SRC_W-1:0]      src;       // Sources seen by every function.
  wire                   wipe;      // Clears the running network state.
  assign src  = {fq_r, sig_s_r}; // R12
  assign wipe = rst_i | restart_i; // R13
  // Input synchroniser; only the second stage is read by the network.
  always_ff @(posedge clk_i) begin
    sig_m_r <= sig_i;
    sig_s_r <= sig_m_r;
  end
  // Timebase divider; delays are counted in ticks so they stay short counters.
  always_ff @(posedge clk_i) begin
    if (rst_i || tick_cnt_r == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 16'h0000;
      tick_r     <= ~rst_i;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r     <= 1'b0;
    end
  end
  // Pending store. Delete wins over create, create over a field write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_FUNC; i++) begin
        p_used_r[i] <= 1'b0;
        p_type_r[i] <= PLG_AND;
        p_ma_r[i]   <= '0;
        p_mb_r[i]   <= '0;
        p_mc_r[i]   <= '0;
        p_md_r[i]   <= '0;
        p_cnt_r[i]  <= CNT_RST;
        p_on_r[i]   <= CNT_RST;
        p_off_r[i]  <= CNT_RST;
        p_inv_r[i]  <= 1'b0;
        p_oen_r[i]  <= 1'b0;
        p_osel_r[i] <= '0;
      end
    end else if (cfg_del_i) begin
      p_used_r[cfg_idx_i] <= 1'b0;
      p_oen_r[cfg_idx_i]  <= 1'b0;
    end else if (cfg_new_i) begin
      // A fresh function is a plain AND with nothing attached.
      p_used_r[cfg_idx_i] <= 1'b1;
      p_type_r[cfg_idx_i] <= PLG_AND; // R7
      p_ma_r[cfg_idx_i]   <= '0;
      p_mb_r[cfg_idx_i]   <= '0;
      p_mc_r[cfg_idx_i]   <= '0;
      p_md_r[cfg_idx_i]   <= '0;
      p_cnt_r[cfg_idx_i]  <= CNT_RST;
      p_on_r[cfg_idx_i]   <= CNT_RST;
      p_off_r[cfg_idx_i]  <= CNT_RST;
      p_inv_r[cfg_idx_i]  <= 1'b0;
      p_oen_r[cfg_idx_i]  <= 1'b0;
      p_osel_r[cfg_idx_i] <= '0;
    end else if (cfg_wr_i && p_used_r[cfg_idx_i]) begin
      p_type_r[cfg_idx_i] <= cfg_type_i; // R8
      p_ma_r[cfg_idx_i]   <= cfg_mask_a_i;
      p_mb_r[cfg_idx_i]   <= cfg_mask_b_i;
      p_mc_r[cfg_idx_i]   <= cfg_mask_c_i;
      p_md_r[cfg_idx_i]   <= cfg_mask_d_i;
      p_cnt_r[cfg_idx_i]  <= cfg_count_i; // R9
      p_on_r[cfg_idx_i]   <= cfg_on_dly_i;
      p_off_r[cfg_idx_i]  <= cfg_off_dly_i;
      p_inv_r[cfg_idx_i]  <= cfg_inv_i;
      p_oen_r[cfg_idx_i]  <= cfg_out_en_i;
      p_osel_r[cfg_idx_i] <= cfg_out_sel_i;
    end
  end
  // Active copy: changes only on restart, so a half-written network never runs.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NUM_FUNC; i++) begin
      if (rst_i) begin
        a_used_r[i] <= 1'b0;
        a_type_r[i] <= PLG_AND;
        a_ma_r[i]   <= '0;
        a_mb_r[i]   <= '0;
        a_mc_r[i]   <= '0;
        a_md_r[i]   <= '0;
        a_cnt_r[i]  <= CNT_RST;
        a_on_r[i]   <= CNT_RST;
        a_off_r[i]  <= CNT_RST;
        a_inv_r[i]  <= 1'b0;
        a_oen_r[i]  <= 1'b0;
        a_osel_r[i] <= '0;
      end else if (restart_i) begin // R13
        a_used_r[i] <= p_used_r[i];
        a_type_r[i] <= p_type_r[i];
        a_ma_r[i]   <= p_ma_r[i];
        a_mb_r[i]   <= p_mb_r[i];
        a_mc_r[i]   <= p_mc_r[i];
        a_md_r[i]   <= p_md_r[i];
        a_cnt_r[i]  <= p_cnt_r[i];
        a_on_r[i]   <= p_on_r[i];
        a_off_r[i]  <= p_off_r[i];
        a_inv_r[i]  <= p_inv_r[i];
        a_oen_r[i]  <= p_oen_r[i] & p_used_r[i];
        a_osel_r[i] <= p_osel_r[i];
      end
    end
  end
  // One evaluation slice per function slot.
  for (genvar g = 0; g < NUM_FUNC; g++) begin : g_fn
    logic             raw;       // Undelayed result of the function.
    logic             dly_q_r;   // Result after on/off delay.
    logic [CNT_W-1:0] dly_cnt_r; // Ticks spent waiting for a change.
    logic [CNT_W-1:0] cnt_r;     // Edge counter.
    logic             edge_p_r;  // Previous count input level.
    logic             lat_r;     // Latch state.
    wire              any_a = |(src & a_ma_r[g]);
    wire              any_b = |(src & a_mb_r[g]);
    wire              any_c = |(src & a_mc_r[g]);
    wire              any_d = |(src & a_md_r[g]);
    // An AND with no inputs is false, not vacuously true.
    wire              all_a = (a_ma_r[g] != '0) && ((src & a_ma_r[g]) == a_ma_r[g]);
    wire              all_b = (a_mb_r[g] != '0) && ((src & a_mb_r[g]) == a_mb_r[g]);
    wire              xor_a = ^(src & a_ma_r[g]);
    wire              none_a = (a_ma_r[g] != '0) && !any_a;
    wire              low_a  = (a_ma_r[g] != '0) && !all_a;
    wire              cnt_hit = (cnt_r >= a_cnt_r[g]);
    wire [CNT_W-1:0]  dly_lim = raw ? a_on_r[g] : a_off_r[g];
    // Type selection; any unused code reads as inactive.
    always_comb begin
      case (a_type_r[g]) // R8
        PLG_AND:     raw = all_a; // R1
        PLG_OR:      raw = any_a;
        PLG_XOR:     raw = xor_a;
        PLG_AND_OR:  raw = all_a | any_b;
        PLG_OR_AND:  raw = any_a & all_b;
        PLG_INV_AND: raw = none_a;
        PLG_INV_OR:  raw = low_a;
        PLG_CNT:     raw = cnt_hit; // R15
        PLG_SRL:     raw = lat_r;
        PLG_SDL:     raw = lat_r;
        default:     raw = 1'b0;
      endcase
      if (!a_used_r[g]) begin
        raw = 1'b0;
      end
    end
    // Counter and latches. Reset input dominates in every sequential type.
    always_ff @(posedge clk_i) begin
      if (wipe) begin
        cnt_r    <= CNT_RST;
        edge_p_r <= 1'b0;
        lat_r    <= 1'b0;
      end else begin
        edge_p_r <= any_a;
        if (any_b) begin // R15 R16
          cnt_r <= CNT_RST;
          lat_r <= 1'b0;
        end else begin
          // Saturate at the setting so the counter never wraps back to zero.
          if (any_a && !edge_p_r && !cnt_hit) begin // R15
            cnt_r <= cnt_r + 16'h0001;
          end
          if (a_type_r[g] == PLG_SDL && any_d) begin
            lat_r <= any_c; // R16
          end else if (any_a) begin
            lat_r <= 1'b1;
          end
        end
      end
    end
    // Activation and deactivation delays, counted in timebase ticks.
    always_ff @(posedge clk_i) begin
      if (wipe) begin
        dly_q_r   <= 1'b0;
        dly_cnt_r <= CNT_RST;
      end else if (raw == dly_q_r) begin
        dly_cnt_r <= CNT_RST;
      end else if (dly_cnt_r >= dly_lim) begin // R10
        dly_q_r   <= raw;
        dly_cnt_r <= CNT_RST;
      end else if (tick_r) begin
        dly_cnt_r <= dly_cnt_r + 16'h0001;
      end
    end
    // Output inversion applies only to functions that exist.
    always_ff @(posedge clk_i) begin
      if (wipe) begin
        fq_r[g] <= 1'b0;
      end else begin
        fq_r[g] <= a_used_r[g] & (dly_q_r ^ a_inv_r[g]); // R11
      end
    end
  end

  // Logic output gathering: every function routed to output j is ORed in.
  logic [NUM_OUT-1:0] out_comb;
  logic [NUM_OUT-1:0] avail_comb;
  always_comb begin
    out_comb   = '0;
    avail_comb = '0;
    for (int i = 0; i < NUM_FUNC; i++) begin
      if (a_oen_r[i] && a_osel_r[i] < OSEL_W'(NUM_OUT)) begin // R4
        out_comb[a_osel_r[i]]   = out_comb[a_osel_r[i]] | fq_r[i];
        avail_comb[a_osel_r[i]] = 1'b1;
      end
    end
  end
  // Output registers, so every result leaves the block straight from a flip-flop.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      logic_out_o <= '0;
      out_avail_o <= '0;
      func_out_o  <= '0;
    end else begin
      logic_out_o <= out_comb;
      out_avail_o <= avail_comb; // R14
      func_out_o  <= fq_r;
    end
  end
  // Usage of the pending configuration, counted over all slots.
  logic [7:0]          n_in;
  logic [7:0]          n_gate;
  logic [NUM_OUT-1:0]  o_map;
  logic [7:0]          n_out;
  always_comb begin
    n_in   = 8'h00;
    n_gate = 8'h00;
    o_map  = '0;
    n_out  = 8'h00;
    for (int i = 0; i < NUM_FUNC; i++) begin
      if (p_used_r[i]) begin
        n_in = n_in + 8'(p_ma_r[i] != '0) + 8'(p_mb_r[i] != '0)
                    + 8'(p_mc_r[i] != '0) + 8'(p_md_r[i] != '0); // R3
        case (p_type_r[i]) // R2
          PLG_AND, PLG_OR, PLG_XOR: n_gate = n_gate + 8'(COST_ONE);
          PLG_SDL:                  n_gate = n_gate + 8'(COST_FOUR);
          default:                  n_gate = n_gate + 8'(COST_TWO);
        endcase
        if (p_oen_r[i] && p_osel_r[i] < OSEL_W'(NUM_OUT)) begin
          o_map[p_osel_r[i]] = 1'b1;
        end
      end
    end
    for (int j = 0; j < NUM_OUT; j++) begin
      n_out = n_out + 8'(o_map[j]);
    end
  end
  wire [15:0] pin_w   = 16'((32'(n_in)   * PCT_FULL) / INGATE_CAP);
  wire [15:0] pgate_w = 16'((32'(n_gate) * PCT_FULL) / GATE_CAP);
  wire [15:0] pout_w  = 16'((32'(n_out)  * PCT_FULL) / OUT_CAP);
  // Registered percentages; over_o flags a load that must not be restarted.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pct_in_o   <= '0;
      pct_gate_o <= '0;
      pct_out_o  <= '0;
      over_o     <= 1'b0;
    end else begin
      pct_in_o   <= pin_w[PCT_W-1:0]; // R5
      pct_gate_o <= pgate_w[PCT_W-1:0];
      pct_out_o  <= pout_w[PCT_W-1:0];
      over_o     <= (pin_w > 16'(PCT_FULL)) || (pgate_w > 16'(PCT_FULL)) || (pout_w > 16'(PCT_FULL)); // R6
    end
  end
endmodule
`default_nettype wire

// [dv/plg_src_model.sv]
/*
  Model of the relay signal sources that feed the logic engine.
  Assumes the bench sets the wanted levels on the falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module plg_src_model
  import plg_pkg::*;
(
  // Wanted levels and the pins that carry them.
  input  wire logic [plg_pkg::NUM_SIG-1:0] want_i,
  output logic      [plg_pkg::NUM_SIG-1:0] sig_o
);
  // Sources are asynchronous to the relay clock, so they settle a little late.
  assign #5 sig_o = want_i;
endmodule
`default_nettype wire

// [dv/plg_engine_asserts.sv]
/*
  Port checker for the logic engine.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module plg_engine_asserts
  import plg_pkg::*;
(
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  input wire logic                        cfg_new_i,
  input wire logic                        cfg_del_i,
  input wire logic                        cfg_wr_i,
  input wire logic                        restart_i,
  input wire logic [plg_pkg::NUM_OUT-1:0] logic_out_o,
  input wire logic [plg_pkg::NUM_OUT-1:0] out_avail_o,
  input wire logic [plg_pkg::PCT_W-1:0]   pct_in_o,
  input wire logic [plg_pkg::PCT_W-1:0]   pct_gate_o,
  input wire logic [plg_pkg::PCT_W-1:0]   pct_out_o,
  input wire logic                        over_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Any change of the pending configuration.
  wire logic edit_w = cfg_new_i | cfg_del_i | cfg_wr_i;
  // Only these can raise usage.
  wire logic grow_w = cfg_new_i | cfg_wr_i;

  a_reset_clear: assert property ($past(rst_i) |-> logic_out_o == '0 && out_avail_o == '0 && pct_gate_o == '0)
    else $error("outputs not cleared by reset");
  a_over_match: assert property (over_o == (pct_in_o > PCT_FULL || pct_gate_o > PCT_FULL || pct_out_o > PCT_FULL))
    else $error("over flag disagrees with usage");
  a_pct_hold: assert property (!edit_w [*3] |=> $stable(pct_gate_o) && $stable(pct_in_o) && $stable(pct_out_o))
    else $error("usage moved without an edit");
  a_avail_restart: assert property ($changed(out_avail_o) |-> $past(restart_i) || $past(restart_i, 2) || $past(rst_i))
    else $error("matrix sources changed without restart");
  a_pct_out_step: assert property (pct_out_o % (PCT_FULL / NUM_OUT) == 0 && pct_out_o <= PCT_FULL)
    else $error("output usage off its steps");
  a_gate_with_in: assert property (pct_in_o != '0 |-> pct_gate_o != '0)
    else $error("inputs used with no gate");
  a_out_in_matrix: assert property (!restart_i && !$past(restart_i) && !$past(restart_i, 2) && !$past(restart_i, 3)
    && !$past(rst_i, 2) |-> (logic_out_o & ~out_avail_o) == '0)
    else $error("output active without matrix source");
  a_over_cause: assert property ($rose(over_o) |-> $past(grow_w, 2))
    else $error("over flag rose without growth");

  // Main scenarios are reached.
  c_restart: cover property (restart_i);
  c_over: cover property ($rose(over_o));
  c_active: cover property (logic_out_o != '0);
endmodule
bind plg_engine plg_engine_asserts u_plg_engine_asserts (.clk_i(clk_i), .rst_i(rst_i), .cfg_new_i(cfg_new_i),
  .cfg_del_i(cfg_del_i), .cfg_wr_i(cfg_wr_i), .restart_i(restart_i), .logic_out_o(logic_out_o),
  .out_avail_o(out_avail_o), .pct_in_o(pct_in_o), .pct_gate_o(pct_gate_o), .pct_out_o(pct_out_o), .over_o(over_o));
`default_nettype wire

// [dv/testbench.sv]
/*
  Self-checking bench for the logic engine.
  Assumes a short delay tick of 4 clocks; inputs move on the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import plg_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, c_new = 1'b0, c_del = 1'b0, c_wr = 1'b0, c_inv = 1'b0;
  logic        c_oen = 1'b0, c_rs = 1'b0, ov, inv, e = 1'b0;
  logic [4:0]  c_idx = '0, c_osel = '0;
  logic [3:0]  c_ty = '0;
  logic [63:0] m_a = '0, m_b = '0, m_c = '0, m_d = '0;
  logic [15:0] c_cnt = '0, c_on = '0, c_off = '0;
  logic [31:0] want = '0, sig, fo;
  logic [19:0] lo, av;
  logic [8:0]  pin, pg, po;
  int          error_cnt = 0, num_checks = 0, seed = 66;

  always #20 clk_i = ~clk_i;

  plg_src_model u_plg_src_model (.want_i(want), .sig_o(sig));
  plg_engine #(.TICK_CYCLES(4)) u_plg_engine (.clk_i(clk_i), .rst_i(rst_i), .sig_i(sig), .cfg_new_i(c_new),
    .cfg_del_i(c_del), .cfg_wr_i(c_wr), .cfg_idx_i(c_idx), .cfg_type_i(c_ty), .cfg_mask_a_i(m_a),
    .cfg_mask_b_i(m_b), .cfg_mask_c_i(m_c), .cfg_mask_d_i(m_d), .cfg_count_i(c_cnt), .cfg_on_dly_i(c_on),
    .cfg_off_dly_i(c_off), .cfg_inv_i(c_inv), .cfg_out_en_i(c_oen), .cfg_out_sel_i(c_osel), .restart_i(c_rs),
    .logic_out_o(lo), .out_avail_o(av), .func_out_o(fo), .pct_in_o(pin), .pct_gate_o(pg), .pct_out_o(po),
    .over_o(ov));

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Create a slot, then write every field into it on the next cycle.
  task automatic put(input logic [4:0] i, input logic [3:0] ty, input logic [63:0] a, b, input logic [15:0] n, on,
                     off, input logic iv, oe, input logic [4:0] os);
    c_idx = i;
    c_new = 1'b1;
    tick(1);
    c_new = 1'b0;
    c_wr = 1'b1;
    {c_ty, m_a, m_b, c_cnt, c_on, c_off, c_inv, c_oen, c_osel} = {ty, a, b, n, on, off, iv, oe, os};
    tick(1);
    c_wr = 1'b0;
  endtask
  task automatic restart();
    c_rs = 1'b1;
    tick(1);
    c_rs = 1'b0;
    tick(1);
  endtask
  task automatic hit(input int b);
    want[b] = 1'b1;
    tick(6);
    want[b] = 1'b0;
    tick(6);
  endtask
  // Expected combinational result over four main and four second inputs.
  function automatic logic expf(input int t, input logic [3:0] a, b);
    case (t)
      0: return &a;
      1: return |a;
      2: return ^a;
      3: return (&a) | (|b);
      4: return (|a) & (&b);
      5: return ~|a;
      default: return ~&a;
    endcase
  endfunction
  task automatic end_of_test();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    tick(2);
    rst_i = 1'b0;
    tick(1);
    chk("pct_gate", 0, pg);
    // Every type in turn; cost is visible in the gate usage.
    for (int t = 0; t < 10; t++) begin
      put(5'h00, t[3:0], 64'h1, '0, '0, '0, '0, 1'b0, 1'b1, 5'h00);
      tick(2);
      chk("pct_gate", (t < 3 ? 1 : (t == 9 ? 4 : 2)) * PCT_FULL / GATE_CAP, pg);
    end
    chk("pct_in", PCT_FULL / INGATE_CAP, pin);
    chk("pct_out", PCT_FULL / OUT_CAP, po);
    c_idx = 5'h01;
    c_new = 1'b1;
    tick(1);
    c_new = 1'b0;
    tick(2);
    chk("pct_gate_new", 5 * PCT_FULL / GATE_CAP, pg);
    c_del = 1'b1;
    tick(1);
    c_del = 1'b0;
    tick(2);
    chk("pct_gate_del", 4 * PCT_FULL / GATE_CAP, pg);
    // A field write to the deleted slot must be ignored.
    c_wr = 1'b1;
    tick(1);
    c_wr = 1'b0;
    tick(2);
    chk("pct_gate_dead_wr", 4 * PCT_FULL / GATE_CAP, pg);
    // Overfill the gate budget; the flag only reports it.
    for (int i = 0; i < 32; i++) put(i[4:0], 4'h9, '0, '0, '0, '0, '0, 1'b0, 1'b0, 5'h00);
    tick(2);
    chk("pct_gate_full", 4 * PCT_FULL, pg);
    chk("over", 1, ov);
    // The over-full load is thrown away by reset and never restarted.
    rst_i = 1'b1;
    tick(1);
    rst_i = 1'b0;
    // Each combinational type under random inputs, slot 1 cascaded on slot 0.
    for (int t = 0; t < 7; t++) begin
      inv = 1'($random(seed));
      put(5'h00, t[3:0], 64'h0000_000F, 64'h0000_00F0, '0, '0, '0, inv, 1'b1, 5'h00);
      put(5'h01, 4'h0, 64'h0000_0001_0000_0000, '0, '0, '0, '0, 1'b0, 1'b1, 5'h01);
      tick(3);
      chk("held_out", e, lo[0]);
      restart();
      tick(4);
      chk("avail", 20'h0_0003, av);
      repeat (8) begin
        want[7:0] = 8'($random(seed));
        tick(7);
        e = expf(t, want[3:0], want[7:4]) ^ inv;
        chk("logic_out", e, lo[0]);
        if (!inv) chk("cascade", e, lo[1]);
        chk("func_out", e, fo[0]);
        chk("func_cascade", e, fo[1]);
      end
    end
    want = '0;
    tick(6);
    // Counter set to three, second input clears.
    put(5'h00, 4'h7, 64'h1, 64'h2, 16'h0003, '0, '0, 1'b0, 1'b1, 5'h00);
    restart();
    hit(0);
    hit(0);
    chk("count2", 0, lo[0]);
    hit(0);
    chk("count3", 1, lo[0]);
    hit(1);
    chk("count_clr", 0, lo[0]);
    // Set/reset latch: reset wins.
    put(5'h00, 4'h8, 64'h1, 64'h2, '0, '0, '0, 1'b0, 1'b1, 5'h00);
    restart();
    hit(0);
    chk("latch_set", 1, lo[0]);
    want[1:0] = 2'h3;
    tick(7);
    chk("latch_both", 0, lo[0]);
    want = '0;
    // Loadable latch takes data on load.
    m_c = 64'h4;
    m_d = 64'h8;
    put(5'h00, 4'h9, '0, '0, '0, '0, '0, 1'b0, 1'b1, 5'h00);
    restart();
    want[2] = 1'b1;
    hit(3);
    chk("load_one", 1, lo[0]);
    want[2] = 1'b0;
    hit(3);
    chk("load_zero", 0, lo[0]);
    // On delay of two ticks and off delay of three.
    put(5'h00, 4'h1, 64'h1, '0, '0, 16'h0002, 16'h0003, 1'b0, 1'b1, 5'h00);
    restart();
    want[0] = 1'b1;
    tick(5);
    chk("on_early", 0, lo[0]);
    tick(10);
    chk("on_late", 1, lo[0]);
    want[0] = 1'b0;
    tick(6);
    chk("off_early", 1, lo[0]);
    tick(14);
    chk("off_late", 0, lo[0]);
    // An undefined type code reads as inactive, even with its input high.
    put(5'h00, 4'hF, 64'h1, '0, '0, '0, '0, 1'b0, 1'b1, 5'h00);
    restart();
    want[0] = 1'b1;
    tick(7);
    chk("bad_type", 0, lo[0]);
    end_of_test();
  end
endmodule
`default_nettype wire
